// ===== tpps_top.sv
// test and probe pin sharing: scan controller, probe mux, pin ownership
// How it works
// - flexible mode, tms low claims tck, tdi, tdo for boundary scan.
// - claimed pins stay in test role until controller reaches logic reset.
// - at logic reset tck, tdi, tdo return to ordinary user pins.
// - five tck edges with tms high always reach logic reset.
// - dedicated mode keeps the pins for test; tms is plain 1149.1.
// - tdi feeds both the scan registers and the probe selection.
// - tdo drives scan data only during shift states; it is otherwise off while in test role.
// - tester supplies tck whenever probe or programming is used.
// - probe A outputs any selected internal node in real time.
// - both probes run together, each with its own selection.
// - a probe pin not probing is an ordinary user pin.
// - a fuse disables probing permanently; no node reaches the probes.
// - each user pin is input, output, tristate or bidirectional.
`include "tpps_regs.svh"
`timescale 1ns/10ps
`default_nettype none
module tpps_top
    import tpps_pkg::*;
#(
    parameter int NODE_N = 16
) (
    input  wire logic                            clk,
    input  wire logic                            rst_b,
    input  wire logic                            tck,
    input  wire logic                            tms,
    input  wire logic                            dedicatedTest,
    input  wire logic                            probeFuse,
    input  wire logic           [`TPPS_NPIN-1:0] pinIn,
    input  wire tpps_pin_ctrl_t [`TPPS_NPIN-1:0] userCtrl,
    input  wire logic               [NODE_N-1:0] probeNode,
    output var  tpps_pin_drv_t  [`TPPS_NPIN-1:0] pinDrv,
    output logic                [`TPPS_NPIN-1:0] userIn,
    output logic                                 testRole,
    output logic                                 probeLocked
);
    localparam int CFG_W = $bits(tpps_probe_cfg_t);

    ////////////////////////////////////////////////////////////////////////
    // helpers

    // standard scan controller walk
    function automatic tpps_tap_t tapNext(input tpps_tap_t s,
                                          input logic m);
        case (s)
            TPPS_TLR:   tapNext = m ? TPPS_TLR   : TPPS_RTI;
            TPPS_RTI:   tapNext = m ? TPPS_SELDR : TPPS_RTI;
            TPPS_SELDR: tapNext = m ? TPPS_SELIR : TPPS_CAPDR;
            TPPS_CAPDR: tapNext = m ? TPPS_EX1DR : TPPS_SHDR;
            TPPS_SHDR:  tapNext = m ? TPPS_EX1DR : TPPS_SHDR;
            TPPS_EX1DR: tapNext = m ? TPPS_UPDR  : TPPS_PADR;
            TPPS_PADR:  tapNext = m ? TPPS_EX2DR : TPPS_PADR;
            TPPS_EX2DR: tapNext = m ? TPPS_UPDR  : TPPS_SHDR;
            TPPS_UPDR:  tapNext = m ? TPPS_SELDR : TPPS_RTI;
            TPPS_SELIR: tapNext = m ? TPPS_TLR   : TPPS_CAPIR;
            TPPS_CAPIR: tapNext = m ? TPPS_EX1IR : TPPS_SHIR;
            TPPS_SHIR:  tapNext = m ? TPPS_EX1IR : TPPS_SHIR;
            TPPS_EX1IR: tapNext = m ? TPPS_UPIR  : TPPS_PAIR;
            TPPS_PAIR:  tapNext = m ? TPPS_EX2IR : TPPS_PAIR;
            TPPS_EX2IR: tapNext = m ? TPPS_UPIR  : TPPS_SHIR;
            TPPS_UPIR:  tapNext = m ? TPPS_SELDR : TPPS_RTI;
            default:    tapNext = TPPS_TLR;
        endcase
    endfunction

    // pad drive for a user pin in each buffer mode
    function automatic tpps_pin_drv_t pinDrive(input tpps_pin_ctrl_t c);
        pinDrive.o = c.o;
        case (c.mode)
            TPPS_IN:  pinDrive.oe = 1'b0;
            TPPS_OUT: pinDrive.oe = 1'b1;
            default:  pinDrive.oe = c.oe; // tristate and bidirectional
        endcase
    endfunction

    // whether a user pin passes its pad level inward
    function automatic logic pinListens(input tpps_mode_t m);
        pinListens = (m == TPPS_IN) || (m == TPPS_BIDIR);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // scan controller, tck domain

    tpps_tap_t                tapState_q;
    tpps_tap_t                tapState_d;
    logic [`TPPS_IR_W-1:0]    irShift_q;
    logic [`TPPS_IR_W-1:0]    ir_q;
    tpps_probe_cfg_t          drShift_q;
    tpps_probe_cfg_t          cfgTck_q;
    logic                     bypass_q;
    logic                     tdoBit_q;
    logic                     tdoEn_q;
    logic                     testActive_q;
    logic                     probeLoad;
    logic                     tdiIn;

    assign tapState_d = tapNext(tapState_q, tms);
    assign tdiIn      = pinIn[`TPPS_PIN_TDI];
    assign probeLoad  = (tapState_q == TPPS_UPDR)
                      && (ir_q == `TPPS_IR_PROBE);

    // state walk; tms high on five edges lands in logic reset
    always_ff @(posedge tck or negedge rst_b) begin
        if (!rst_b) begin
            tapState_q <= TPPS_TLR;
        end else begin
            tapState_q <= tapState_d;
        end
    end

    // pins owned from leaving logic reset until returning to it
    always_ff @(posedge tck or negedge rst_b) begin
        if (!rst_b) begin
            testActive_q <= 1'b0;
        end else begin
            testActive_q <= (tapState_d != TPPS_TLR);
        end
    end

    // instruction register; logic reset falls back to bypass
    always_ff @(posedge tck or negedge rst_b) begin
        if (!rst_b) begin
            irShift_q <= `TPPS_IR_CAPTURE;
            ir_q      <= `TPPS_IR_BYPASS;
        end else begin
            case (tapState_q)
                TPPS_TLR:   ir_q      <= `TPPS_IR_BYPASS;
                TPPS_CAPIR: irShift_q <= `TPPS_IR_CAPTURE;
                TPPS_SHIR:  irShift_q <= {tdiIn,
                                          irShift_q[`TPPS_IR_W-1:1]};
                TPPS_UPIR:  ir_q      <= irShift_q;
                default:    ir_q      <= ir_q;
            endcase
        end
    end

    // data registers: probe selection chain or one-bit bypass
    always_ff @(posedge tck or negedge rst_b) begin
        if (!rst_b) begin
            drShift_q <= '0;
            bypass_q  <= 1'b0;
        end else if (tapState_q == TPPS_CAPDR) begin
            drShift_q <= cfgTck_q;
            bypass_q  <= 1'b0;
        end else if (tapState_q == TPPS_SHDR) begin
            if (ir_q == `TPPS_IR_PROBE) begin
                drShift_q <= {tdiIn, drShift_q[CFG_W-1:1]};
            end else begin
                bypass_q <= tdiIn;
            end
        end
    end

    // probe selection survives logic reset so probes keep running after
    // the test pins are handed back
    always_ff @(posedge tck or negedge rst_b) begin
        if (!rst_b) begin
            cfgTck_q <= '0;
        end else if (probeLoad) begin
            cfgTck_q <= drShift_q;
        end
    end

    // serial out launched on the rising edge: the pad path through the
    // system clock domain needs most of a tck period
    always_ff @(posedge tck or negedge rst_b) begin
        if (!rst_b) begin
            tdoBit_q <= 1'b0;
            tdoEn_q  <= 1'b0;
        end else begin
            tdoEn_q <= (tapState_q == TPPS_SHIR)
                    || (tapState_q == TPPS_SHDR);
            if (tapState_q == TPPS_SHIR) begin
                tdoBit_q <= irShift_q[0];
            end else if (tapState_q == TPPS_SHDR) begin
                tdoBit_q <= (ir_q == `TPPS_IR_PROBE) ? drShift_q[0]
                                                     : bypass_q;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // crossings into the system clock domain

    localparam int SYNC_W = `TPPS_NPIN + 5;

    logic [SYNC_W-1:0]     syncOut;
    logic [`TPPS_NPIN-1:0] pinInS;
    logic                  dedS;
    logic                  fuseS;
    logic                  testActS;
    logic                  tdoBitS;
    logic                  tdoEnS;
    tpps_probe_cfg_t       cfgNew;
    logic                  cfgNewValid;

    // tdo bit and enable change together only at shift boundaries, and
    // the tester samples a full tck later, so their skew is harmless
    tpps_sync2 #(.WIDTH(SYNC_W)) uLevelSync (
        .clk     (clk),
        .rst_b   (rst_b),
        .asyncIn ({pinIn, dedicatedTest, probeFuse, testActive_q,
                   tdoBit_q, tdoEn_q}),
        .syncOut (syncOut)
    );
    assign {pinInS, dedS, fuseS, testActS, tdoBitS, tdoEnS} = syncOut;

    // tck only runs while the tester works the probes, so the selection
    // crosses by handshake
    tpps_xfer #(.WIDTH(CFG_W)) uCfgXfer (
        .srcClk   (tck),
        .dstClk   (clk),
        .rst_b    (rst_b),
        .srcValid (probeLoad),
        .srcData  (cfgTck_q == drShift_q ? cfgTck_q : drShift_q),
        .dstData  (cfgNew),
        .dstValid (cfgNewValid)
    );

    ////////////////////////////////////////////////////////////////////////
    // pin ownership, system clock domain

    tpps_probe_cfg_t cfg_q;
    logic            roleA_q;
    logic            roleB_q;

    // latest probe selection
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cfg_q <= '0;
        end else if (cfgNewValid) begin
            cfg_q <= cfgNew;
        end
    end

    // lock is sticky; the fuse itself is irreversible
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            probeLocked <= 1'b0;
        end else if (fuseS) begin
            probeLocked <= 1'b1;
        end
    end

    // dedicated mode owns the pins outright; flexible follows the scan
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            testRole <= 1'b0;
        end else begin
            testRole <= dedS | testActS;
        end
    end

    // each probe pin probes only while enabled and never once locked
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            roleA_q <= 1'b0;
            roleB_q <= 1'b0;
        end else begin
            roleA_q <= cfg_q.enA & ~probeLocked & ~fuseS;
            roleB_q <= cfg_q.enB & ~probeLocked & ~fuseS;
        end
    end

    // pad drive: user buffer unless the pin is taken for test or probe
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pinDrv <= '0;
        end else begin
            for (int i = 0; i < `TPPS_NPIN; i++) begin
                pinDrv[i] <= pinDrive(userCtrl[i]);
            end
            if (testRole) begin
                pinDrv[`TPPS_PIN_TCK] <= '0;
                pinDrv[`TPPS_PIN_TDI] <= '0;
                pinDrv[`TPPS_PIN_TDO] <= '{o: tdoBitS, oe: tdoEnS};
            end
            if (roleA_q) begin
                pinDrv[`TPPS_PIN_PRA] <= '{o: probeNode[cfg_q.selA],
                                           oe: 1'b1};
            end
            if (roleB_q) begin
                pinDrv[`TPPS_PIN_PRB] <= '{o: probeNode[cfg_q.selB],
                                           oe: 1'b1};
            end
        end
    end

    // pad levels reach user logic on pins it listens to, except tck, tdi, tdo in test role
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            userIn <= '0;
        end else begin
            for (int i = 0; i < `TPPS_NPIN; i++) begin
                userIn[i] <= pinInS[i] & pinListens(userCtrl[i].mode);
            end
            if (testRole) begin
                userIn[`TPPS_PIN_TCK] <= 1'b0;
                userIn[`TPPS_PIN_TDI] <= 1'b0;
                userIn[`TPPS_PIN_TDO] <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks, tck domain

    property p_reset_walk;
        @(posedge tck) disable iff (!rst_b)
        tms [*5] |=> (tapState_q == TPPS_TLR);
    endproperty
    a_reset_walk: assert property (p_reset_walk)
        else $error("five tms-high edges did not reach logic reset");

    property p_claim;
        @(posedge tck) disable iff (!rst_b)
        (tapState_q == TPPS_TLR) && !tms |=> testActive_q;
    endproperty
    a_claim: assert property (p_claim)
        else $error("tms low did not claim the test pins");

    property p_hold;
        @(posedge tck) disable iff (!rst_b)
        testActive_q && !tms |=> testActive_q;
    endproperty
    a_hold: assert property (p_hold)
        else $error("test pins released before logic reset");

    property p_release;
        @(posedge tck) disable iff (!rst_b)
        (tapState_q == TPPS_SELIR) && tms |=> !testActive_q;
    endproperty
    a_release: assert property (p_release)
        else $error("test pins kept after logic reset");

    property p_probe_load;
        @(posedge tck) disable iff (!rst_b)
        probeLoad |=> (cfgTck_q == $past(drShift_q));
    endproperty
    a_probe_load: assert property (p_probe_load)
        else $error("probe selection not loaded from scan chain");

    property p_tdo_en;
        @(posedge tck) disable iff (!rst_b)
        (tapState_q == TPPS_SHDR) |=> tdoEn_q;
    endproperty
    a_tdo_en: assert property (p_tdo_en)
        else $error("tdo not enabled during shift");

    ////////////////////////////////////////////////////////////////////////
    // checks, system clock domain

    property p_ded;
        @(posedge clk) disable iff (!rst_b)
        dedicatedTest [*4] |=> testRole;
    endproperty
    a_ded: assert property (p_ded)
        else $error("dedicated mode did not hold the test role");

    property p_probe_a;
        @(posedge clk) disable iff (!rst_b)
        roleA_q |=> pinDrv[`TPPS_PIN_PRA].oe
            && (pinDrv[`TPPS_PIN_PRA].o == $past(probeNode[cfg_q.selA]));
    endproperty
    a_probe_a: assert property (p_probe_a)
        else $error("probe A does not show the selected node");

    property p_lock;
        @(posedge clk) disable iff (!rst_b)
        probeLocked |=> !roleA_q && !roleB_q && probeLocked;
    endproperty
    a_lock: assert property (p_lock)
        else $error("probe active after lock");

    property p_no_contend;
        @(posedge clk) disable iff (!rst_b)
        testRole |=> !pinDrv[`TPPS_PIN_TCK].oe && !pinDrv[`TPPS_PIN_TDI].oe;
    endproperty
    a_no_contend: assert property (p_no_contend)
        else $error("user driver on a pin in test role");

    property p_user_in_mode;
        @(posedge clk) disable iff (!rst_b)
        !roleB_q && (userCtrl[`TPPS_PIN_PRB].mode == TPPS_IN)
            |=> !pinDrv[`TPPS_PIN_PRB].oe;
    endproperty
    a_user_in_mode: assert property (p_user_in_mode)
        else $error("input-only user pin is driving");

    c_claim: cover property (@(posedge clk) disable iff (!rst_b)
        $rose(testRole));
    c_release: cover property (@(posedge clk) disable iff (!rst_b)
        $fell(testRole));
    c_both_probes: cover property (@(posedge clk) disable iff (!rst_b)
        roleA_q && roleB_q);
    c_locked: cover property (@(posedge clk) disable iff (!rst_b)
        $rose(probeLocked));
endmodule
`default_nettype wire

// ===== tpps_regs.svh
// constants for the test probe pin sharing block
`ifndef TPPS_REGS_SVH
`define TPPS_REGS_SVH

// instruction register width, codes and capture pattern
`define TPPS_IR_W        2
`define TPPS_IR_BYPASS   2'h3
`define TPPS_IR_PROBE    2'h1
`define TPPS_IR_CAPTURE  2'h1

// width of one probe node selection
`define TPPS_SEL_W       4

// shared pin indices
`define TPPS_NPIN        5
`define TPPS_PIN_TCK     3'h0
`define TPPS_PIN_TDI     3'h1
`define TPPS_PIN_TDO     3'h2
`define TPPS_PIN_PRA     3'h3
`define TPPS_PIN_PRB     3'h4

// tck edges with tms high that always reach logic reset
`define TPPS_RESET_TMS_CYCLES 5

`endif

// ===== tpps_pkg.sv
// types shared by the test probe pin sharing block
`include "tpps_regs.svh"
package tpps_pkg;

    // boundary scan controller states
    typedef enum logic [3:0] {
        TPPS_TLR    = 4'b0000,
        TPPS_RTI    = 4'b0001,
        TPPS_SELDR  = 4'b0010,
        TPPS_CAPDR  = 4'b0011,
        TPPS_SHDR   = 4'b0100,
        TPPS_EX1DR  = 4'b0101,
        TPPS_PADR   = 4'b0110,
        TPPS_EX2DR  = 4'b0111,
        TPPS_UPDR   = 4'b1000,
        TPPS_SELIR  = 4'b1001,
        TPPS_CAPIR  = 4'b1010,
        TPPS_SHIR   = 4'b1011,
        TPPS_EX1IR  = 4'b1100,
        TPPS_PAIR   = 4'b1101,
        TPPS_EX2IR  = 4'b1110,
        TPPS_UPIR   = 4'b1111
    } tpps_tap_t;

    // user pin buffer configuration
    typedef enum logic [1:0] {
        TPPS_IN    = 2'b00,
        TPPS_OUT   = 2'b01,
        TPPS_TRI   = 2'b10,
        TPPS_BIDIR = 2'b11
    } tpps_mode_t;

    // what user logic asks of one pin
    typedef struct packed {
        tpps_mode_t mode;
        logic       o;
        logic       oe;
    } tpps_pin_ctrl_t;

    // what goes out to one pad
    typedef struct packed {
        logic o;
        logic oe;
    } tpps_pin_drv_t;

    // probe selection loaded over the test port
    typedef struct packed {
        logic                   enB;
        logic [`TPPS_SEL_W-1:0] selB;
        logic                   enA;
        logic [`TPPS_SEL_W-1:0] selA;
    } tpps_probe_cfg_t;

endpackage

// ===== tpps_sync2.sv
// two flip-flop level synchroniser
`timescale 1ns/10ps
`default_nettype none
module tpps_sync2 #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic             rst_b,
    input  wire logic [WIDTH-1:0] asyncIn,
    output logic      [WIDTH-1:0] syncOut
);
    logic [WIDTH-1:0] meta_q;

    // first stage feeds only the second stage
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            meta_q  <= '0;
            syncOut <= '0;
        end else begin
            meta_q  <= asyncIn;
            syncOut <= meta_q;
        end
    end
endmodule
`default_nettype wire

// ===== tpps_xfer.sv
// toggle handshake that carries one word from src clock to dst clock
`timescale 1ns/10ps
`default_nettype none
module tpps_xfer #(
    parameter int WIDTH = 8
) (
    input  wire logic             srcClk,
    input  wire logic             dstClk,
    input  wire logic             rst_b,
    input  wire logic             srcValid,
    input  wire logic [WIDTH-1:0] srcData,
    output logic      [WIDTH-1:0] dstData,
    output logic                  dstValid
);
    logic [WIDTH-1:0] hold_q;
    logic             tog_q;
    logic             togS;
    logic             togSeen_q;

    // word is held still while the toggle crosses; a new load needs at
    // least three dst cycles, which one tck period always gives
    always_ff @(posedge srcClk or negedge rst_b) begin
        if (!rst_b) begin
            hold_q <= '0;
            tog_q  <= 1'b0;
        end else if (srcValid) begin
            hold_q <= srcData;
            tog_q  <= ~tog_q;
        end
    end

    tpps_sync2 #(.WIDTH(1)) uTogSync (
        .clk     (dstClk),
        .rst_b   (rst_b),
        .asyncIn (tog_q),
        .syncOut (togS)
    );

    // capture when the synchronised toggle changes
    always_ff @(posedge dstClk or negedge rst_b) begin
        if (!rst_b) begin
            togSeen_q <= 1'b0;
            dstData   <= '0;
            dstValid  <= 1'b0;
        end else begin
            togSeen_q <= togS;
            dstValid  <= togS ^ togSeen_q;
            if (togS ^ togSeen_q) begin
                dstData <= hold_q;
            end
        end
    end
endmodule
`default_nettype wire

// ===== tpps_tester.sv
// tester model that drives the scan port on its own test clock
`include "tpps_regs.svh"
`timescale 1ns/10ps
`default_nettype none
module tpps_tester (
    output logic tck,
    output logic tms,
    output logic tdi
);
    // test clock stands still outside frames, tms starts high and keeps its last value between steps
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
    end
    // one 125 ns period; the rising edge sits off the system clock's
    // edges, and tdi flips while tck is high so stale data never looks
    // valid between shifts
    task automatic step(input logic m, input logic d);
        tms = m;
        tdi = d;
        #55 tck = 1'b1;
        #35 tdi = ~d;
        #35 tck = 1'b0;
    endtask
    // five tms-high clocks reach logic reset from any state
    task automatic park();
        repeat (`TPPS_RESET_TMS_CYCLES) step(1'b1, 1'b0);
    endtask
endmodule
`default_nettype wire

// ===== tpps_top_tb_top.sv
// self-checking bench for the test probe pin sharing block
`timescale 1ns/10ps
`default_nettype none
module tpps_top_tb_top;
    import tpps_pkg::*;
    logic                  clk, rst_b, dedicatedTest, probeFuse;
    wire logic             tck, tms, tdi;
    wire logic [4:0]       pinIn;
    logic      [4:0]       extLvl, userIn;
    tpps_pin_ctrl_t [4:0]  userCtrl;
    tpps_pin_drv_t  [4:0]  pinDrv;
    logic      [15:0]      probeNode;
    logic                  testRole, probeLocked;
    tpps_probe_cfg_t       cfg;
    logic      [31:0]      r;
    integer                seed, n_fail, n_tests, i, k;
    // pad level: tck and tdi straight from the tester; others own driver when enabled, else the board's level
    assign pinIn[0] = tck;
    assign pinIn[1] = tdi;
    assign pinIn[2] = pinDrv[2].oe ? pinDrv[2].o : extLvl[2];
    assign pinIn[3] = pinDrv[3].oe ? pinDrv[3].o : extLvl[3];
    assign pinIn[4] = pinDrv[4].oe ? pinDrv[4].o : extLvl[4];
    tpps_tester tpps_tester_inst (.tck(tck), .tms(tms), .tdi(tdi));
    tpps_top tpps_top_inst (.clk(clk), .rst_b(rst_b), .tck(tck),
        .tms(tms), .dedicatedTest(dedicatedTest), .probeFuse(probeFuse),
        .pinIn(pinIn), .userCtrl(userCtrl), .probeNode(probeNode),
        .pinDrv(pinDrv), .userIn(userIn), .testRole(testRole),
        .probeLocked(probeLocked));
    ////////////////////////////////////////////////////////////////////
    // 40 MHz system clock
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    task automatic chk(input string nm, input logic [15:0] e,
                       input logic [15:0] g);
        n_tests++;
        if (e !== g) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    // user drive expected from the buffer mode
    function automatic logic [15:0] drvExp(tpps_pin_ctrl_t c);
        logic en;
        en = (c.mode == TPPS_OUT) ? 1'b1 : (c.mode == TPPS_IN) ? 1'b0 : c.oe;
        return {14'h0, c.o & en, en};
    endfunction
    // level user logic should see: listening modes pass the pad level
    function automatic logic inExp(input int p);
        tpps_pin_ctrl_t c;
        logic [15:0]    d;
        logic           lvl;
        c = userCtrl[p];
        d = drvExp(c);
        lvl = (p < 2) ? pinIn[p] : (d[0] ? c.o : extLvl[p]);
        return lvl & ((c.mode == TPPS_IN) || (c.mode == TPPS_BIDIR));
    endfunction
    task automatic chkUser(input int p);
        chk("pinDrv user", drvExp(userCtrl[p]),
            {14'h0, pinDrv[p].o & pinDrv[p].oe, pinDrv[p].oe});
        chk("userIn", {15'h0, inExp(p)}, {15'h0, userIn[p]});
    endtask
    // sample well away from the edge so clocked updates have landed
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask
    task automatic chkProbes();
        chk("probe a", {14'h0, probeNode[cfg.selA], 1'b1}, pinDrv[3]);
        chk("probe b", {14'h0, probeNode[cfg.selB], 1'b1}, pinDrv[4]);
    endtask
    task automatic end_of_test();
        if (n_fail == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // a hung handshake must not stall the run
    initial begin
        #100000;
        n_fail++;
        end_of_test();
    end
    ////////////////////////////////////////////////////////////////////
    initial begin
        seed = 55796;
        n_fail = 0;
        n_tests = 0;
        rst_b = 1'b0;
        dedicatedTest = 1'b0;
        probeFuse = 1'b0;
        probeNode = 16'h0;
        extLvl = 5'h0;
        userCtrl = '0;
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        // every buffer mode visits every pin, random data alongside
        for (k = 0; k < 4; k++) begin
            @(posedge clk);
            for (i = 0; i < 5; i++) begin
                r = $random(seed);
                userCtrl[i] <= {2'(i + k), r[1:0]};
            end
            extLvl <= 5'($random(seed));
            settle(4);
            for (i = 0; i < 5; i++) chkUser(i);
        end
        chk("role idle", 16'h0, testRole);
        tpps_tester_inst.step(1'b0, 1'b0);
        settle(6);
        chk("role claim", 16'h1, testRole);
        chk("tck oe", 16'h0, pinDrv[0].oe);
        chk("tdi oe", 16'h0, pinDrv[1].oe);
        // probe select instruction, then ten selection bits lsb first
        r = $random(seed);
        cfg = tpps_probe_cfg_t'(r[9:0]);
        cfg.enA = 1'b1;
        cfg.enB = 1'b1;
        tpps_tester_inst.step(1'b1, 1'b0);
        tpps_tester_inst.step(1'b1, 1'b0);
        tpps_tester_inst.step(1'b0, 1'b0);
        tpps_tester_inst.step(1'b0, 1'b0);
        tpps_tester_inst.step(1'b0, 1'b1);
        tpps_tester_inst.step(1'b1, 1'b0);
        tpps_tester_inst.step(1'b1, 1'b0);
        tpps_tester_inst.step(1'b1, 1'b0);
        tpps_tester_inst.step(1'b0, 1'b0);
        tpps_tester_inst.step(1'b0, 1'b0);
        for (i = 0; i < 9; i++) tpps_tester_inst.step(1'b0, cfg[i]);
        settle(5);
        chk("tdo oe", 16'h1, pinDrv[2].oe);
        tpps_tester_inst.step(1'b1, cfg[9]);
        tpps_tester_inst.step(1'b1, 1'b0);
        tpps_tester_inst.step(1'b0, 1'b0);
        for (k = 0; k < 3; k++) begin
            @(posedge clk);
            probeNode <= 16'($random(seed));
            settle(3);
            chkProbes();
        end
        // read the selection back: capture, then ten shifts that put the
        // same bits back so the update leaves the selection unchanged
        tpps_tester_inst.step(1'b1, 1'b0);
        tpps_tester_inst.step(1'b0, 1'b0);
        tpps_tester_inst.step(1'b0, 1'b0);
        for (i = 0; i < 10; i++) begin
            tpps_tester_inst.step(i == 9, cfg[i]);
            settle(5);
            chk("tdo bit", {15'h0, cfg[i]}, {15'h0, pinDrv[2].o});
        end
        tpps_tester_inst.step(1'b1, 1'b0);
        tpps_tester_inst.step(1'b0, 1'b0);
        // two tms-high clocks are not yet logic reset
        tpps_tester_inst.step(1'b1, 1'b0);
        tpps_tester_inst.step(1'b1, 1'b0);
        settle(6);
        chk("role held", 16'h1, testRole);
        repeat (3) tpps_tester_inst.step(1'b1, 1'b0);
        settle(6);
        chk("role released", 16'h0, testRole);
        for (i = 0; i < 3; i++) chkUser(i);
        @(posedge clk);
        probeFuse <= 1'b1;
        settle(7);
        chk("locked", 16'h1, probeLocked);
        chkUser(3);
        chkUser(4);
        @(posedge clk);
        probeFuse <= 1'b0;
        settle(5);
        chk("lock sticky", 16'h1, probeLocked);
        @(posedge clk);
        dedicatedTest <= 1'b1;
        settle(6);
        chk("role dedicated", 16'h1, testRole);
        tpps_tester_inst.park();
        settle(6);
        chk("role kept", 16'h1, testRole);
        chk("tck oe ded", 16'h0, pinDrv[0].oe);
        end_of_test();
    end
endmodule
`default_nettype wire
